// ===== hw/srsbe_top.sv
/*
 * Sideband logic: link reset output pin and multicast event pin,
 * configured over an AHB-Lite slave.
 * Assumes the link layer decodes control symbols and accepts one
 * outgoing event symbol per cycle when tx_ready is high; the pad ring
 * resolves the two-way pins from the enables.
 */
`timescale 1ns/10ps
module srsbe_top #(
    parameter int PULSE_CYC = srsbe_pkg::RESET_PULSE_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link symbols
    input wire srsbe_pkg::srsbe_rx_sym_type rx_sym,
    output srsbe_pkg::srsbe_tx_sym_type tx_sym,
    input wire logic tx_ready,
    // Scan test mode
    input wire logic scan_mode,
    // Link reset pin
    input wire logic link_reset_out_n_i,
    output logic link_reset_out_n_o,
    output logic link_reset_out_n_oe,
    // Multicast event pin
    input wire logic multicast_event_pin_i,
    output logic multicast_event_pin_o,
    output logic multicast_event_pin_oe
);

    localparam int CW = srsbe_pkg::CMD_W;
    localparam int NC = srsbe_pkg::NUM_CMD;
    localparam int PW = $clog2(PULSE_CYC + 1);

    generate
        if (PULSE_CYC < 1) begin : g_bad
            $error("srsbe_top needs PULSE_CYC of at least one");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Register bus

    logic self_reset_enable_r, self_reset_enable_nxt;
    logic event_pin_direction_r, event_pin_direction_nxt;
    logic forward_a_r, forward_a_nxt;
    logic multicast_symbol_enable_r, multicast_symbol_enable_nxt;
    logic [NC-1:0] event_trigger_enable_r, event_trigger_enable_nxt;
    logic [NC-1:0] event_capture_enable_r, event_capture_enable_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] status;
    logic accept;

    // Event and reset state, declared here for the status word
    logic [2:0] rst_cnt_r, rst_cnt_nxt;
    logic [PW-1:0] pulse_r, pulse_nxt;
    logic pin_out_r, pin_out_nxt;
    logic [NC-1:0] pend_r, pend_nxt;
    srsbe_pkg::srsbe_tx_sym_type tx_r, tx_nxt;
    logic ev_level, ev_edge;

    assign accept = hsel && hready && htrans[1] &&
        hsize == srsbe_pkg::HSIZE_WORD;

    // Status word shows the block's state and the reset pin level
    always_comb begin
        status = '0;
        status[srsbe_pkg::ST_PIN_BIT] = event_pin_direction_r ?
            pin_out_r : ev_level;
        status[srsbe_pkg::ST_RSTOUT_BIT] = pulse_r != '0;
        status[srsbe_pkg::ST_RSTPIN_BIT] = link_reset_out_n_i;
        status[srsbe_pkg::ST_CNT_LSB +: 3] = rst_cnt_r;
        status[srsbe_pkg::ST_PEND_LSB +: NC] = pend_r;
    end

    // Writes land in the data phase; read data is captured at the
    // address phase, so the master's idle data phase keeps it fresh
    always_comb begin
        self_reset_enable_nxt = self_reset_enable_r;
        event_pin_direction_nxt = event_pin_direction_r;
        forward_a_nxt = forward_a_r;
        multicast_symbol_enable_nxt = multicast_symbol_enable_r;
        event_trigger_enable_nxt = event_trigger_enable_r;
        event_capture_enable_nxt = event_capture_enable_r;
        wr_pend_nxt = accept && hwrite;
        wr_addr_nxt = haddr[7:0];
        rdata_nxt = rdata_r;
        if (wr_pend_r) begin
            if (wr_addr_r == srsbe_pkg::CTRL_OFS) begin
                self_reset_enable_nxt = hwdata[srsbe_pkg::SELF_RESET_ENABLE_BIT];
                event_pin_direction_nxt = hwdata[srsbe_pkg::DIR_BIT];
            end else if (wr_addr_r == srsbe_pkg::FWD_OFS) begin
                forward_a_nxt = hwdata[srsbe_pkg::FWD_A_BIT];
                multicast_symbol_enable_nxt =
                    hwdata[srsbe_pkg::MSYM_EN_BIT];
            end else if (wr_addr_r == srsbe_pkg::TRIG_OFS) begin
                event_trigger_enable_nxt = hwdata[NC-1:0];
            end else if (wr_addr_r == srsbe_pkg::CAP_OFS) begin
                event_capture_enable_nxt = hwdata[NC-1:0];
            end
        end
        if (accept && !hwrite) begin
            rdata_nxt = '0;
            if (haddr[7:0] == srsbe_pkg::CTRL_OFS) begin
                rdata_nxt[srsbe_pkg::SELF_RESET_ENABLE_BIT] = self_reset_enable_r;
                rdata_nxt[srsbe_pkg::DIR_BIT] = event_pin_direction_r;
            end else if (haddr[7:0] == srsbe_pkg::FWD_OFS) begin
                rdata_nxt[srsbe_pkg::FWD_A_BIT] = forward_a_r;
                rdata_nxt[srsbe_pkg::MSYM_EN_BIT] =
                    multicast_symbol_enable_r;
            end else if (haddr[7:0] == srsbe_pkg::TRIG_OFS) begin
                rdata_nxt[NC-1:0] = event_trigger_enable_r;
            end else if (haddr[7:0] == srsbe_pkg::CAP_OFS) begin
                rdata_nxt[NC-1:0] = event_capture_enable_r;
            end else if (haddr[7:0] == srsbe_pkg::STAT_OFS) begin
                rdata_nxt = status;
            end
        end
    end

    // Configuration registers; device reset clears them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            self_reset_enable_r <= 1'b0;
            event_pin_direction_r <= 1'b0;
            forward_a_r <= 1'b0;
            multicast_symbol_enable_r <= 1'b0;
            event_trigger_enable_r <= '0;
            event_capture_enable_r <= '0;
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
            rdata_r <= '0;
        end else begin
            self_reset_enable_r <= self_reset_enable_nxt;
            event_pin_direction_r <= event_pin_direction_nxt;
            forward_a_r <= forward_a_nxt;
            multicast_symbol_enable_r <= multicast_symbol_enable_nxt;
            event_trigger_enable_r <= event_trigger_enable_nxt;
            event_capture_enable_r <= event_capture_enable_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Zero wait states; unmapped addresses read zero, writes dropped
    assign hrdata = rdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////
    // Link reset pin

    // Count consecutive reset symbols; any other symbol restarts
    always_comb begin
        rst_cnt_nxt = rst_cnt_r;
        pulse_nxt = pulse_r;
        if (pulse_r != '0) begin
            pulse_nxt = pulse_r - PW'(1);
        end
        if (rx_sym.valid) begin
            if (!rx_sym.is_reset) begin
                rst_cnt_nxt = '0;
            end else if (rst_cnt_r == 3'(srsbe_pkg::RST_SYM_NEEDED - 1)) begin
                rst_cnt_nxt = '0;
                if (self_reset_enable_r) begin
                    pulse_nxt = PW'(PULSE_CYC);
                end
            end else begin
                rst_cnt_nxt = rst_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_cnt_r <= '0;
            pulse_r <= '0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    // Pin is released to the tester only in scan mode
    assign link_reset_out_n_o = pulse_r == '0;
    assign link_reset_out_n_oe = !scan_mode;

    ////////////////////////////////////////////////////////////////////
    // Multicast event pin

    srsbe_edge_sync #(
        .STAGES(srsbe_pkg::SYNC_STAGES)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(multicast_event_pin_i),
        .level(ev_level),
        .edge_pulse(ev_edge)
    );

    // Edges queue one symbol per trigger mask bit; a new edge merges
    // with a still-pending command, so very fast edges may coalesce
    always_comb begin
        pend_nxt = pend_r;
        tx_nxt = tx_r;
        pin_out_nxt = pin_out_r;
        if (tx_r.valid && tx_ready) begin
            tx_nxt.valid = 1'b0;
        end
        if (!tx_nxt.valid) begin
            for (int i = NC - 1; i >= 0; i--) begin
                if (pend_r[i]) begin
                    tx_nxt.valid = 1'b1;
                    tx_nxt.cmd = CW'(i);
                end
            end
            if (tx_nxt.valid && !tx_r.valid) begin
                pend_nxt[tx_nxt.cmd] = 1'b0;
            end else if (tx_nxt.valid && tx_ready) begin
                pend_nxt[tx_nxt.cmd] = 1'b0;
            end
        end
        // New edge set wins over the bit just cleared
        if (!event_pin_direction_r && ev_edge && forward_a_r &&
            multicast_symbol_enable_r) begin
            pend_nxt = pend_nxt | event_trigger_enable_r;
        end
        if (event_pin_direction_r && rx_sym.valid && rx_sym.is_multicast_event_pin &&
            event_capture_enable_r[rx_sym.cmd]) begin
            pin_out_nxt = !pin_out_r;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= '0;
            tx_r <= '0;
            pin_out_r <= 1'b0;
        end else begin
            pend_r <= pend_nxt;
            tx_r <= tx_nxt;
            pin_out_r <= pin_out_nxt;
        end
    end

    assign tx_sym = tx_r;
    assign multicast_event_pin_o = pin_out_r;
    assign multicast_event_pin_oe = event_pin_direction_r;

endmodule

// ===== hw/srsbe_pkg.sv
/*
 * Constants, register map and symbol carriers for the serial-link
 * sideband block that ties the link reset pin and the multicast event
 * pin to the link.
 * Assumes a 50 MHz hclk and a link layer that presents one decoded
 * control symbol per cycle on a valid strobe.
 */
// Function
// - Four consecutive reset symbols plus enable drive reset low
// - Reset pin is output, input only in scan
// - Direction bit selects event pin input or output
// - Each input edge sends one multicast event symbol per trigger mask bit not already pending
// - Command from forward, symbol enable, trigger mask
// - Output pin toggles on captured command symbols
// - Device reset clears all logic and configuration
package srsbe_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_SYM_NEEDED = 4;
    localparam int SYNC_STAGES = 2;

    // Command field of a multicast event symbol
    localparam int CMD_W = 3;
    localparam int NUM_CMD = 1 << CMD_W;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FWD_OFS = 8'h04;
    localparam logic [7:0] TRIG_OFS = 8'h08;
    localparam logic [7:0] CAP_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;

    // Control register fields
    localparam int SELF_RESET_ENABLE_BIT = 0;
    localparam int DIR_BIT = 1;
    // Forward control fields
    localparam int FWD_A_BIT = 0;
    localparam int MSYM_EN_BIT = 1;
    // Status fields
    localparam int ST_PIN_BIT = 0;
    localparam int ST_RSTOUT_BIT = 1;
    localparam int ST_RSTPIN_BIT = 2;
    localparam int ST_CNT_LSB = 4;
    localparam int ST_PEND_LSB = 8;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // Symbol received from the link layer
    typedef struct packed {
        logic valid;
        logic is_reset;
        logic is_multicast_event_pin;
        logic [CMD_W-1:0] cmd;
    } srsbe_rx_sym_type;

    // Multicast event symbol handed to the link layer
    typedef struct packed {
        logic valid;
        logic [CMD_W-1:0] cmd;
    } srsbe_tx_sym_type;

endpackage

// ===== hw/srsbe_edge_sync.sv
/*
 * Synchroniser and edge detector for one asynchronous pin.
 * Assumes the pin may change at any time relative to hclk.
 */
`timescale 1ns/10ps
module srsbe_edge_sync #(
    parameter int STAGES = srsbe_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Pin and results
    input wire logic pin_in,
    output logic level,
    output logic edge_pulse
);

    logic [STAGES-1:0] sync_r;
    logic [STAGES-1:0] sync_nxt;
    logic prev_r;
    logic prev_nxt;

    generate
        if (STAGES < 2) begin : g_bad
            $error("srsbe_edge_sync needs at least two stages");
        end
    endgenerate

    // Shift chain; only the last stage is looked at
    always_comb begin
        sync_nxt = {sync_r[STAGES-2:0], pin_in};
        prev_nxt = sync_r[STAGES-1];
    end

    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_r <= '0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Both edges count; one pulse per settled change
    assign level = sync_r[STAGES-1];
    assign edge_pulse = sync_r[STAGES-1] ^ prev_r;

endmodule

// ===== dv/srsbe_top_sva.sv
/* Port checker for the sideband block.
   Assumes one hclk domain and the active-low asynchronous hresetn. */
`timescale 1ns/10ps
module srsbe_top_sva (
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Link and pins
    input wire srsbe_pkg::srsbe_rx_sym_type rx_sym,
    input wire srsbe_pkg::srsbe_tx_sym_type tx_sym,
    input wire logic tx_ready,
    input wire logic scan_mode,
    input wire logic link_reset_out_n_o,
    input wire logic link_reset_out_n_oe,
    input wire logic multicast_event_pin_i,
    input wire logic multicast_event_pin_o,
    input wire logic multicast_event_pin_oe
);
    logic [1:0] rcnt_r;
    logic wr_r;
    // Run of reset symbols; two bits wrap after the fourth like the block
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcnt_r <= 2'h0;
            wr_r <= 1'h0;
        end else begin
            if (rx_sym.valid)
                rcnt_r <= rx_sym.is_reset ? rcnt_r + 2'h1 : 2'h0;
            wr_r <= hsel && hready && htrans[1] && hwrite;
        end
    end
////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rst_pulse_s;
        (!link_reset_out_n_o) [*3];
    endsequence
    sequence tx_stall_s;
        tx_sym.valid && !tx_ready;
    endsequence
    fire_cause_a: assert property ($fell(link_reset_out_n_o) |->
        $past(rx_sym.valid && rx_sym.is_reset && rcnt_r == 2'h3))
        else $error("reset pin fell without a fourth reset symbol");
    pulse_len_a: assert property ($fell(link_reset_out_n_o) |->
        rst_pulse_s) else $error("reset pulse too short");
    scan_oe_a: assert property (
        link_reset_out_n_oe == !scan_mode)
        else $error("reset pin enable does not follow scan mode");
    dir_write_a: assert property ($changed(multicast_event_pin_oe)
        |-> $past(wr_r)) else $error("event pin direction moved alone");
    tx_hold_a: assert property (tx_stall_s |=>
        tx_sym.valid && $stable(tx_sym.cmd))
        else $error("event symbol dropped while stalled");
    sync_delay_a: assert property ($changed(multicast_event_pin_i)
        && !multicast_event_pin_oe && !tx_sym.valid |=> !tx_sym.valid)
        else $error("event symbol sent before synchronising");
    toggle_cause_a: assert property ($changed(multicast_event_pin_o)
        |-> $past(rx_sym.valid && rx_sym.is_multicast_event_pin))
        else $error("event pin toggled without an event symbol");
    reset_clear_a: assert property ($rose(hresetn) |->
        link_reset_out_n_o && !tx_sym.valid && !multicast_event_pin_oe
        && !multicast_event_pin_o) else $error("state left after reset");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule

bind srsbe_top srsbe_top_sva u_sva (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .rx_sym, .tx_sym, .tx_ready,
    .scan_mode, .link_reset_out_n_o, .link_reset_out_n_oe,
    .multicast_event_pin_i, .multicast_event_pin_o, .multicast_event_pin_oe);

// ===== dv/srsbe_link_model.sv
/* Link layer and board stand-in facing the sideband block.
   Assumes the bench calls send and sets the board levels. */
`timescale 1ns/10ps
module srsbe_link_model (
    // Clock
    input wire logic hclk,
    // Link symbols
    output srsbe_pkg::srsbe_rx_sym_type rx_sym,
    input wire srsbe_pkg::srsbe_tx_sym_type tx_sym,
    output logic tx_ready,
    // Pins
    input wire logic rst_o,
    input wire logic rst_oe,
    output logic rst_pin,
    input wire logic evt_o,
    input wire logic evt_oe,
    output logic evt_pin
);
    logic slow = 1'h0;
    logic board_evt = 1'h0;
    logic board_rst = 1'h1;
    logic [2:0] got_q[$];
    initial rx_sym = '0;
    initial tx_ready = 1'h1;
    // Board drives a pin only while the block has released it
    assign rst_pin = rst_oe ? rst_o : board_rst;
    assign evt_pin = evt_oe ? evt_o : board_evt;
////////////////////////////////////////////////////////////////////////
    // Slow mode stalls every other cycle so the offer must be held
    always @(posedge hclk) begin
        if (tx_sym.valid && tx_ready)
            got_q.push_back(tx_sym.cmd);
        tx_ready <= slow ? !tx_ready : 1'h1;
    end
    // One control symbol, then a quiet cycle
    task automatic send(input logic r, input logic m, input logic [2:0] c);
        rx_sym <= {1'h1, r, m, c};
        @(posedge hclk);
        rx_sym <= '0;
        @(posedge hclk);
    endtask
endmodule

// ===== dv/srsbe_top_tb.sv
/* Self-checking bench for the sideband block.
   Assumes the link model and the bound checker are compiled before. */
`timescale 1ns/10ps
module srsbe_top_tb;
    localparam int PULSE = 3;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic scan_mode = 1'h0;
    // Board's test port reset; the block has no pin that reads it
    logic test_port_reset_n = 1'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, tx_ready;
    logic rst_o, rst_oe, rst_pin, evt_o, evt_oe, evt_pin;
    srsbe_pkg::srsbe_rx_sym_type rx_sym;
    srsbe_pkg::srsbe_tx_sym_type tx_sym;
    int n_errors = 0;
    int comparisons = 0;
    always #(srsbe_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;
    srsbe_top #(.PULSE_CYC(PULSE)) DUT (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .rx_sym, .tx_sym, .tx_ready, .scan_mode,
        .link_reset_out_n_i(rst_pin), .link_reset_out_n_o(rst_o),
        .link_reset_out_n_oe(rst_oe), .multicast_event_pin_i(evt_pin),
        .multicast_event_pin_o(evt_o), .multicast_event_pin_oe(evt_oe));
    srsbe_link_model u_link (.hclk, .rx_sym, .tx_sym, .tx_ready, .rst_o,
        .rst_oe, .rst_pin, .evt_o, .evt_oe, .evt_pin);
////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Single word transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= srsbe_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= srsbe_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    // Reset clears pins, symbols and the four configuration registers, unmapped reads 0
    task automatic t_reset;
        logic [7:0] ofs[5];
        ofs = '{srsbe_pkg::CTRL_OFS, srsbe_pkg::FWD_OFS,
            srsbe_pkg::TRIG_OFS, srsbe_pkg::CAP_OFS, 8'h20};
        @(posedge hclk);
        hresetn <= 1'h0;
        test_port_reset_n <= 1'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        test_port_reset_n <= 1'h1;
        @(negedge hclk);
        check(32'({rst_o, evt_oe, evt_o, tx_sym.valid}), 32'h8);
        @(posedge hclk);
        foreach (ofs[i]) begin
            ahb(1'h0, ofs[i], 32'h0);
            check(rd, 32'h0);
        end
    endtask
    // A broken run does not fire; the fourth in a row does, once enabled,
    // and a later full run with the enable cleared stays quiet
    task automatic t_linkrst;
        ahb(1'h1, srsbe_pkg::CTRL_OFS, 32'h1);
        for (int i = 0; i < 12; i++) begin
            u_link.send(i != 3, 1'h0, 3'h0);
            @(negedge hclk);
            check(32'(rst_o), 32'(i != 7));
            @(posedge hclk);
            if (i == 7)
                ahb(1'h1, srsbe_pkg::CTRL_OFS, 32'h0);
        end
    endtask
    // Scan test turns the reset pin round so the board drives it
    task automatic t_scan;
        scan_mode <= 1'h1;
        for (int v = 0; v < 2; v++) begin
            u_link.board_rst <= v[0];
            repeat (4) @(posedge hclk);
            ahb(1'h0, srsbe_pkg::STAT_OFS, 32'h0);
            check(32'(rd[srsbe_pkg::ST_RSTPIN_BIT]), 32'(v));
        end
        check(32'(rst_oe), 32'h0);
        scan_mode <= 1'h0;
        @(negedge hclk);
        check(32'(rst_oe), 32'h1);
        @(posedge hclk);
    endtask
    // Each pin edge sends one symbol per trigger bit while link stalls; none once forward is cleared
    task automatic t_evt_in;
        ahb(1'h1, srsbe_pkg::FWD_OFS, 32'h3);
        ahb(1'h1, srsbe_pkg::TRIG_OFS, 32'h0A);
        check(32'(evt_oe), 32'h0);
        u_link.slow <= 1'h1;
        for (int e = 0; e < 3; e++) begin
            if (e == 2)
                ahb(1'h1, srsbe_pkg::FWD_OFS, 32'h0);
            u_link.got_q.delete();
            u_link.board_evt <= !u_link.board_evt;
            // Long enough for both symbols and any stray third one
            repeat (30) @(posedge hclk);
            check(32'(u_link.got_q.size()), e < 2 ? 32'h2 : 32'h0);
            if (e < 2)
                check(32'({u_link.got_q[0], u_link.got_q[1]}), 32'h0B);
        end
    endtask
    // Output pin toggles only on the one captured command
    task automatic t_evt_out;
        ahb(1'h1, srsbe_pkg::CTRL_OFS, 32'h2);
        ahb(1'h1, srsbe_pkg::CAP_OFS, 32'h10);
        check(32'(evt_oe), 32'h1);
        for (int c = 0; c < 9; c++) begin
            u_link.send(c == 8, c < 8, 3'(c % 8));
            @(negedge hclk);
            check(32'(evt_o), 32'(c >= 4));
            @(posedge hclk);
        end
    endtask
    initial begin
        t_reset();
        t_linkrst();
        t_scan();
        t_evt_in();
        t_evt_out();
        t_reset();
        print_verdict();
    end
    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        n_errors++;
        print_verdict();
    end
endmodule
